// [rtl/swc_pkg.sv]
// package of constants for the sleep and wake-up sequencer
package swc_pkg;
  // register map, byte offsets on the plain register port
  localparam logic [15:0] SWC_OPTION_ADDR = 16'h0081;
  localparam logic [15:0] SWC_CONFIG_ADDR = 16'h2007;
  localparam logic [15:0] SWC_STATUS_ADDR = 16'h0003;
  localparam logic [15:0] SWC_CTRL_ADDR = 16'h0004;
  localparam logic [7:0] SWC_OPTION_RESET = 8'hff;
  localparam logic [7:0] SWC_CTRL_RESET = 8'h00;
  // config word bit fields
  localparam int SWC_CFG_WDOG_EN_BIT = 2;
  localparam int SWC_CFG_PWRT_EN_BIT = 3;
  localparam int SWC_CFG_BROWNOUT_BIT = 6;
  // option register bit fields
  localparam int SWC_OPT_PRESCALER_ASSIGN_BIT = 3;
  localparam int SWC_OPT_PS_LO_BIT = 0;
  localparam int SWC_OPT_PS_HI_BIT = 2;
  // status register bit fields
  localparam int SWC_ST_PD_BIT = 0;
  localparam int SWC_ST_TO_BIT = 1;
  localparam int SWC_ST_ASLEEP_BIT = 2;
  localparam int SWC_ST_OSC_BIT = 3;
  // ctrl register: global interrupt enable bit
  localparam int SWC_CTRL_GIE_BIT = 0;
  // interrupt vector
  localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;
  // clock and timing
  localparam int SWC_CLK_HZ = 10_000_000;
  localparam int SWC_OST_US = 100;
  localparam int SWC_OST_CYCLES = (SWC_OST_US * (SWC_CLK_HZ / 1_000_000) < 1) ? 1
                                 : SWC_OST_US * (SWC_CLK_HZ / 1_000_000);
  localparam int SWC_DUMMY_CYCLES = 2;
  localparam int SWC_WDOG_MS = 18;
  localparam int SWC_WDOG_CYCLES = SWC_WDOG_MS * (SWC_CLK_HZ / 1000);
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    SWC_RUN = 5'h01,
    SWC_SLEEP = 5'h02,
    SWC_OST = 5'h04,
    SWC_NEXT = 5'h08,
    SWC_DUMMY = 5'h10
  } swc_state_t;
endpackage

// [rtl/swc_sleep_ctrl.sv]
// sleep entry and wake-up sequencer for the processor core
`timescale 1ns/1ps
module swc_sleep_ctrl
  import swc_pkg::*;
#(
  parameter int WDOG_CYCLES = SWC_WDOG_CYCLES,
  parameter int OST_CYCLES = SWC_OST_CYCLES,
  parameter int IO_WIDTH = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] config_word,
  input wire logic halt_op,
  input wire logic watchdog_clear_op,
  input wire logic [12:0] next_pc,
  input wire logic [2:0] irq_enable,
  input wire logic [2:0] irq_flag,
  input wire logic external_reset_pin_n,
  input wire logic [IO_WIDTH-1:0] io_out_in,
  input wire logic [IO_WIDTH-1:0] io_oe_n_in,
  output logic [IO_WIDTH-1:0] io_out,
  output logic [IO_WIDTH-1:0] io_oe_n,
  output logic core_reset,
  output logic osc_enable,
  output logic exec_enable,
  output logic prefetch_req,
  output logic [12:0] prefetch_pc,
  output logic vector_req,
  output logic [12:0] vector_pc,
  output logic powerdown_flag,
  output logic timeout_flag,
  output logic asleep
);
  localparam int OW = $clog2(OST_CYCLES + 1);

  swc_state_t state_q, state_d;
  logic [7:0] option_q;
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic cfg_taken_q;
  logic [OW-1:0] ost_q;
  logic [1:0] dummy_q;
  logic vec_pend_q;
  logic pin_sync;
  logic pin_rst;
  logic [2:0] irq_sync;
  logic wdt_timeout;
  logic wdt_clear;
  logic wdt_en;
  logic irq_wake;
  logic sleep_wake;
  logic global_irq_enable;

  initial
  begin
    if (OST_CYCLES < 1 || IO_WIDTH < 1)
      $error("bad sequencer parameters");
  end

  // reset pin and interrupt flags come from outside the clock domain
  swc_sync2 #(.WIDTH(4)) u_sync
  (
    .clk(clk),
    .reset(reset),
    .async_in({~external_reset_pin_n, irq_flag}),
    .sync_out({pin_sync, irq_sync})
  );

  assign pin_rst = pin_sync;
  assign global_irq_enable = ctrl_q[SWC_CTRL_GIE_BIT];
  assign wdt_en = cfg_q[SWC_CFG_WDOG_EN_BIT];
  // individual enable only, global enable ignored
  assign irq_wake = |(irq_enable & irq_sync);
  // watchdog wake needs config enable
  assign sleep_wake = irq_wake || (wdt_en && wdt_timeout);
  // clear on halt, clear op, and on any wake
  assign wdt_clear = halt_op || watchdog_clear_op || (state_q == SWC_SLEEP && sleep_wake);

  swc_watchdog #(.TIMEOUT_CYCLES(WDOG_CYCLES)) u_wdog
  (
    .clk(clk),
    .reset(reset || pin_rst),
    .enable(wdt_en),
    .clear(wdt_clear),
    .use_prescaler(option_q[SWC_OPT_PRESCALER_ASSIGN_BIT]),
    .prescale_sel(option_q[SWC_OPT_PS_HI_BIT:SWC_OPT_PS_LO_BIT]),
    .timeout(wdt_timeout)
  );

  // config word latched once after reset release, it is a strap
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_q <= 8'h00;
      cfg_taken_q <= 1'b0;
    end
    else if (!cfg_taken_q)
    begin
      cfg_q <= config_word;
      cfg_taken_q <= 1'b1;
    end
  end

  // software registers
  always_ff @(posedge clk)
  begin
    if (reset || pin_rst)
    begin
      option_q <= SWC_OPTION_RESET;
      ctrl_q <= SWC_CTRL_RESET;
    end
    else if (reg_write)
    begin
      if (reg_addr == SWC_OPTION_ADDR)
        option_q <= reg_wdata;
      if (reg_addr == SWC_CTRL_ADDR)
        ctrl_q <= reg_wdata;
    end
  end

  // read data valid the cycle after the read strobe, unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      unique case (reg_addr)
        SWC_OPTION_ADDR: reg_rdata <= option_q;
        SWC_CONFIG_ADDR: reg_rdata <= cfg_q;
        SWC_CTRL_ADDR: reg_rdata <= ctrl_q;
        SWC_STATUS_ADDR: reg_rdata <= {4'h0, osc_enable, asleep, timeout_flag, powerdown_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SWC_RUN:
        // only the halt instruction enters sleep; pending wake completes halt then wakes
        if (halt_op)
          state_d = irq_wake ? SWC_NEXT : SWC_SLEEP;
      SWC_SLEEP:
        if (sleep_wake)
          state_d = SWC_OST;
      SWC_OST:
        // no fetch until oscillator start-up delay elapses
        if (ost_q == OW'(OST_CYCLES - 1))
          state_d = SWC_NEXT;
      SWC_NEXT:
        // prefetched instruction runs first, then vector if enabled
        state_d = vec_pend_q ? SWC_DUMMY : SWC_RUN;
      SWC_DUMMY:
        if (dummy_q == 2'(SWC_DUMMY_CYCLES - 1))
          state_d = SWC_RUN;
      default: state_d = SWC_RUN;
    endcase
  end

  // state register; pin reset forces a full restart, no prefetch kept
  always_ff @(posedge clk)
  begin
    if (reset || pin_rst)
      state_q <= SWC_RUN;
    else
      state_q <= state_d;
  end

  // oscillator start-up and dummy cycle counters
  always_ff @(posedge clk)
  begin
    if (reset || state_q != SWC_OST)
      ost_q <= '0;
    else
      ost_q <= ost_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset || state_q != SWC_DUMMY)
      dummy_q <= 2'h0;
    else
      dummy_q <= dummy_q + 2'h1;
  end

  // vector decision taken at wake from global enable and an interrupt cause
  always_ff @(posedge clk)
  begin
    if (reset || pin_rst)
      vec_pend_q <= 1'b0;
    else if ((state_q == SWC_SLEEP && sleep_wake) || (state_q == SWC_RUN && halt_op))
      vec_pend_q <= global_irq_enable && irq_wake;
    else if (state_q == SWC_RUN)
      vec_pend_q <= 1'b0;
  end

  // power-down flag: set on power-up, cleared by halt; timeout flag: set by halt, cleared by watchdog
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      powerdown_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end
    else
    begin
      if (state_q == SWC_RUN && halt_op)
      begin
        powerdown_flag <= 1'b0;
        timeout_flag <= 1'b1;
      end
      // timeout after a halt in the same cycle still wins: the watchdog clear beats the halt set
      if (wdt_en && wdt_timeout)
        timeout_flag <= 1'b0;
    end
  end

  // core reset: pin, or watchdog timeout while awake; internal only, pin never driven
  always_ff @(posedge clk)
  begin
    if (reset)
      core_reset <= 1'b1;
    else
      core_reset <= pin_rst || (wdt_en && wdt_timeout && state_q != SWC_SLEEP);
  end

  // oscillator, execution gate and sleep indicator
  always_ff @(posedge clk)
  begin
    if (reset || pin_rst)
    begin
      osc_enable <= 1'b1;
      exec_enable <= 1'b1;
      asleep <= 1'b0;
    end
    else
    begin
      osc_enable <= state_d != SWC_SLEEP;
      exec_enable <= state_d == SWC_RUN || state_d == SWC_NEXT;
      asleep <= state_d == SWC_SLEEP;
    end
  end

  // prefetch of pc+1 during halt, and vector request after dummy cycles
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prefetch_req <= 1'b0;
      prefetch_pc <= 13'h0000;
      vector_req <= 1'b0;
      vector_pc <= 13'h0000;
    end
    else
    begin
      prefetch_req <= state_q == SWC_RUN && halt_op;
      if (state_q == SWC_RUN && halt_op)
        prefetch_pc <= next_pc;
      vector_req <= state_q == SWC_DUMMY && state_d == SWC_RUN;
      vector_pc <= SWC_IRQ_VECTOR;
    end
  end

  // io frozen from the halt onward; hi-z is kept because oe is frozen too
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      io_out <= '0;
      io_oe_n <= '1;
    end
    else if (state_d == SWC_RUN || state_d == SWC_NEXT || state_d == SWC_DUMMY)
    begin
      io_out <= io_out_in;
      io_oe_n <= io_oe_n_in;
    end
  end

  a_io_held: assert property (@(posedge clk) disable iff (reset)
    (asleep && $past(asleep)) |-> $stable(io_out) && $stable(io_oe_n))
    else $error("io changed during sleep");

  a_sleep_cause: assert property (@(posedge clk) disable iff (reset)
    $rose(asleep) |-> $past(halt_op))
    else $error("sleep without halt");

  a_pd_cleared: assert property (@(posedge clk) disable iff (reset)
    (state_q == SWC_RUN && halt_op && !pin_rst) |=> !powerdown_flag)
    else $error("pd not cleared by halt");

  a_osc_off: assert property (@(posedge clk) disable iff (reset)
    asleep |-> !osc_enable)
    else $error("oscillator on in sleep");

  a_no_exec_ost: assert property (@(posedge clk) disable iff (reset || pin_rst)
    (state_q == SWC_OST) |=> !exec_enable || state_q != SWC_OST)
    else $error("executing before start-up delay");

  a_wdt_reset: assert property (@(posedge clk) disable iff (reset)
    (wdt_en && wdt_timeout && state_q == SWC_SLEEP && !pin_rst) |=> !core_reset)
    else $error("watchdog wake caused reset");

  a_prefetch_pc: assert property (@(posedge clk) disable iff (reset)
    (state_q == SWC_RUN && halt_op) |=> prefetch_req && prefetch_pc == $past(next_pc))
    else $error("no prefetch on halt");

  a_vector_gap: assert property (@(posedge clk) disable iff (reset || pin_rst)
    (state_q == SWC_NEXT && vec_pend_q) |=> state_q == SWC_DUMMY ##1 state_q == SWC_DUMMY ##1 vector_req)
    else $error("vector not after two dummy cycles");

  a_no_vector_gie: assert property (@(posedge clk) disable iff (reset || pin_rst)
    (state_q == SWC_NEXT && !vec_pend_q) |=> state_q == SWC_RUN)
    else $error("vectored without global enable");
endmodule // swc_sleep_ctrl

// [rtl/swc_sync2.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module swc_sync2
  import swc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // swc_sync2

// [rtl/swc_watchdog.sv]
// watchdog counter with optional prescaler
`timescale 1ns/1ps
module swc_watchdog
  import swc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = SWC_WDOG_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic clear,
  input wire logic use_prescaler,
  input wire logic [2:0] prescale_sel,
  output logic timeout
);
  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  logic [CW-1:0] count_q;
  logic [7:0] pre_q;
  logic tick;

  initial
  begin
    if (TIMEOUT_CYCLES < 2)
      $error("watchdog timeout too short");
  end

  // prescaler tick: divide by 2^(sel+1) when assigned
  assign tick = !use_prescaler || (pre_q == (8'(2) << prescale_sel) - 8'h01);

  // clear zeroes both count and prescaler
  always_ff @(posedge clk)
  begin
    if (reset || clear || !enable)
    begin
      count_q <= '0;
      pre_q <= 8'h00;
      timeout <= 1'b0;
    end
    else
    begin
      pre_q <= tick ? 8'h00 : pre_q + 8'h01;
      timeout <= 1'b0;
      if (tick)
      begin
        if (count_q == CW'(TIMEOUT_CYCLES - 1))
        begin
          count_q <= '0;
          timeout <= 1'b1;
        end
        else
          count_q <= count_q + 1'b1;
      end
    end
  end
endmodule // swc_watchdog

// [verification/swc_core_model.sv]
// behavioural model of the instruction pipeline facing the sleep sequencer
`timescale 1ns/1ps
module swc_core_model
(
  input wire logic clk,
  input wire logic exec_enable,
  output logic halt_op,
  output logic watchdog_clear_op,
  output logic [12:0] next_pc,
  output logic [7:0] io_out_in,
  output logic [7:0] io_oe_n_in
);
  // quiet pipeline at time zero
  initial
  begin
    halt_op = 1'b0;
    watchdog_clear_op = 1'b0;
    next_pc = 13'h0000;
    io_out_in = 8'ha5;
    io_oe_n_in = 8'h0f;
  end

  // a stopped core no longer holds its pin drive, so scramble it every cycle
  always @(posedge clk)
    if (exec_enable)
    begin
      io_out_in <= 8'ha5;
      io_oe_n_in <= 8'h0f;
    end
    else
    begin
      io_out_in <= ~io_out_in;
      io_oe_n_in <= ~io_oe_n_in;
    end

  // one halt cycle carrying pc plus one, then the pc moves on
  task automatic do_halt(input logic [12:0] pc);
    @(posedge clk);
    halt_op <= 1'b1;
    next_pc <= pc;
    @(posedge clk);
    halt_op <= 1'b0;
    next_pc <= ~pc;
    #1;
  endtask

  // one watchdog clear cycle
  task automatic do_clear();
    @(posedge clk);
    watchdog_clear_op <= 1'b1;
    @(posedge clk);
    watchdog_clear_op <= 1'b0;
  endtask
endmodule // swc_core_model

// [verification/tb.sv]
// self-checking bench for the sleep and wake-up sequencer
`timescale 1ns/1ps
module tb;
  import swc_pkg::*;
  localparam int WD_C = 20;
  localparam int OST_C = 4;
  typedef struct packed {logic wr; logic [15:0] addr; logic [7:0] data; logic [7:0] exp;} swc_row_t;
  logic clk, reset, reg_write, reg_read, external_reset_pin_n, halt_op, watchdog_clear_op;
  logic core_reset, osc_enable, exec_enable, prefetch_req, vector_req, powerdown_flag, timeout_flag, asleep;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, config_word, io_out_in, io_oe_n_in, io_out, io_oe_n;
  logic [12:0] next_pc, prefetch_pc, vector_pc;
  logic [2:0] irq_enable, irq_flag;
  int errors = 0;
  int checks_done = 0;
  // register rows: write rows carry data, read rows the expected value
  swc_row_t rows [12] = '{
    '{1'b0, SWC_OPTION_ADDR, 8'h00, 8'hff}, '{1'b1, SWC_OPTION_ADDR, 8'h00, 8'h00},
    '{1'b0, SWC_OPTION_ADDR, 8'h00, 8'h00}, '{1'b1, SWC_CONFIG_ADDR, 8'hff, 8'h00},
    '{1'b0, SWC_CONFIG_ADDR, 8'h00, 8'h00}, '{1'b0, SWC_STATUS_ADDR, 8'h00, 8'h0b},
    '{1'b1, SWC_STATUS_ADDR, 8'h00, 8'h00}, '{1'b0, SWC_STATUS_ADDR, 8'h00, 8'h0b},
    '{1'b0, 16'h0055, 8'h00, 8'h00}, '{1'b1, SWC_CTRL_ADDR, 8'h01, 8'h00},
    '{1'b0, SWC_CTRL_ADDR, 8'h00, 8'h01}, '{1'b1, SWC_CTRL_ADDR, 8'h00, 8'h00}};

  swc_sleep_ctrl #(.WDOG_CYCLES(WD_C), .OST_CYCLES(OST_C)) i_dut (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .config_word(config_word), .halt_op(halt_op), .watchdog_clear_op(watchdog_clear_op),
    .next_pc(next_pc), .irq_enable(irq_enable), .irq_flag(irq_flag), .external_reset_pin_n(external_reset_pin_n),
    .io_out_in(io_out_in), .io_oe_n_in(io_oe_n_in), .io_out(io_out), .io_oe_n(io_oe_n), .core_reset(core_reset),
    .osc_enable(osc_enable), .exec_enable(exec_enable), .prefetch_req(prefetch_req), .prefetch_pc(prefetch_pc),
    .vector_req(vector_req), .vector_pc(vector_pc), .powerdown_flag(powerdown_flag),
    .timeout_flag(timeout_flag), .asleep(asleep));

  swc_core_model i_core (.clk(clk), .exec_enable(exec_enable), .halt_op(halt_op),
    .watchdog_clear_op(watchdog_clear_op), .next_pc(next_pc), .io_out_in(io_out_in), .io_oe_n_in(io_oe_n_in));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // bounded wait on one output; running out ends the run as a failure
  task automatic waitv(input int sel, input logic val, input int lim, output int n);
    logic s;
    for (n = 0; n < lim; n++)
    begin
      case (sel)
        0: s = asleep;
        1: s = exec_enable;
        2: s = core_reset;
        default: s = vector_req;
      endcase
      if (s === val)
        return;
      @(posedge clk);
      #1;
    end
    errors++;
    complete_run();
  endtask

  task automatic apply_reset();
    reset <= 1'b1;
    repeat (11) @(posedge clk);
    #1;
    chk("reset state", 16'({powerdown_flag, core_reset, osc_enable, exec_enable, asleep, io_oe_n}), 16'h1eff);
    // release on the edge itself, after the twelfth reset cycle
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  initial
  begin
    int n;
    logic [7:0] v;
    clk = 1'b0;
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    config_word = 8'h00;
    irq_enable = 3'b000;
    irq_flag = 3'b000;
    external_reset_pin_n = 1'b1;
    // watchdog disabled in the first phase
    apply_reset();
    foreach (rows[i])
      if (rows[i].wr)
        reg_wr(rows[i].addr, rows[i].data);
      else
      begin
        reg_rd(rows[i].addr, v);
        chk("register", 16'(v), 16'(rows[i].exp));
      end
    // interrupt wake with global enable clear
    irq_enable <= 3'b001;
    i_core.do_halt(13'h0123);
    chk("sleep entry", 16'({asleep, osc_enable, powerdown_flag, timeout_flag, prefetch_req}), 16'h0013);
    chk("prefetch pc", 16'(prefetch_pc), 16'h0123);
    irq_flag <= 3'b010;
    repeat (30) @(posedge clk);
    #1;
    chk("still asleep", 16'(asleep), 16'h0001);
    chk("io hold", {io_out, io_oe_n}, 16'ha50f);
    irq_flag <= 3'b011;
    waitv(0, 1'b0, 8, n);
    waitv(1, 1'b1, 20, n);
    chk("start-up delay", 16'(n >= OST_C), 16'h0001);
    repeat (6)
    begin
      @(posedge clk);
      #1;
      chk("in line resume", 16'({vector_req, exec_enable}), 16'h0001);
    end
    // interrupt wake with global enable set vectors after the next instruction
    irq_flag <= 3'b000;
    reg_wr(SWC_CTRL_ADDR, 8'h01);
    i_core.do_halt(13'h0200);
    irq_flag <= 3'b001;
    waitv(1, 1'b1, 20, n);
    waitv(3, 1'b1, 8, n);
    chk("dummy cycles", 16'(n >= 2), 16'h0001);
    chk("vector pc", 16'(vector_pc), 16'(SWC_IRQ_VECTOR));
    irq_flag <= 3'b000;
    reg_wr(SWC_CTRL_ADDR, 8'h00);
    // flag already pending at halt: no sleep at all
    // comparator source this time, so enable bits 0 and 2 both get used; bit 1 is never enabled
    irq_enable <= 3'b100;
    irq_flag <= 3'b100;
    repeat (4) @(posedge clk);
    i_core.do_halt(13'h0300);
    chk("pending wake", 16'({asleep, powerdown_flag}), 16'h0000);
    irq_flag <= 3'b000;
    repeat (6) @(posedge clk);
    // reset pin wakes with a full reset
    i_core.do_halt(13'h0400);
    external_reset_pin_n <= 1'b0;
    waitv(2, 1'b1, 8, n);
    chk("pin wake", 16'({asleep, osc_enable}), 16'h0001);
    external_reset_pin_n <= 1'b1;
    waitv(2, 1'b0, 8, n);
    // second phase with the watchdog enabled and no prescaler
    config_word <= 8'h04;
    apply_reset();
    reg_wr(SWC_OPTION_ADDR, 8'h00);
    repeat (5)
    begin
      i_core.do_clear();
      repeat (12) @(posedge clk);
      #1;
      chk("clear holds off", 16'({core_reset, timeout_flag}), 16'h0001);
    end
    i_core.do_halt(13'h0500);
    waitv(0, 1'b0, 40, n);
    chk("watchdog wake", 16'({core_reset, timeout_flag}), 16'h0000);
    chk("halt clears count", 16'(n == WD_C + 1), 16'h0001);
    waitv(1, 1'b1, 20, n);
    waitv(2, 1'b1, 40, n);
    // wake clears the count, so the awake timeout lands a full period after the wake edge
    chk("awake timeout", 16'({n == WD_C + 1 - OST_C, timeout_flag}), 16'h0002);
    complete_run();
  end
endmodule // tb
